// ---- hdl/gpb_pkg.sv ----
// Purpose: Shared constants and types for the general I/O port bank.
// Assumes: Eight port slots of eight bits each, one system clock.
// Notes:   Capability masks are indexed by the port slot number.
package gpb_pkg;

  localparam int GPB_NPORT = 8;
  localparam int GPB_WIDTH = 8;

  typedef enum logic [2:0] {
    PORT_1,
    PORT_2,
    PORT_5,
    PORT_D,
    PORT_E,
    PORT_F,
    PORT_H,
    PORT_I
  } gpb_port_e;

  typedef enum logic [2:0] {
    REG_DIR,
    REG_LATCH,
    REG_LEVEL,
    REG_IBUF,
    REG_PULL,
    REG_ODRAIN
  } gpb_reg_e;

  typedef struct packed {
    gpb_port_e port;
    gpb_reg_e  sel;
  } gpb_acc_s;

  // One bit per port slot
  localparam logic [7:0] GPB_HAS_DIR    = 8'hFB;
  localparam logic [7:0] GPB_HAS_PULL   = 8'hF8;
  localparam logic [7:0] GPB_HAS_ODRAIN = 8'h22;
  localparam logic [7:0] GPB_HAS_PERIPH = 8'h03;

  // Bits on which a peripheral may drive the pin
  localparam logic [7:0] GPB_P1_OUT_MASK = 8'h77;
  localparam logic [7:0] GPB_P2_OUT_MASK = 8'hFF;

  localparam logic [7:0] GPB_DIR_RST    = 8'h00;
  localparam logic [7:0] GPB_LATCH_RST  = 8'h00;
  localparam logic [7:0] GPB_IBUF_RST   = 8'h00;
  localparam logic [7:0] GPB_PULL_RST   = 8'h00;
  localparam logic [7:0] GPB_ODRAIN_RST = 8'h00;

endpackage

// ---- hdl/gpb_port_bank.sv ----
// Purpose: General I/O port bank with direction, output latch, pin level,
//          input buffer, pull-up and open-drain control.
// Assumes: Control writes and reads arrive on the same clock; pins are
//          asynchronous and pass two flip-flops before use.
// Notes:   Pin drive, pull-up and level outputs are registered, so a
//          control change shows on the pins one edge after it is stored.
`timescale 1ns/10ps
module gpb_port_bank
  import gpb_pkg::*;
(
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_n_in,
  input  wire logic                                 wr_en_in,
  input  wire gpb_acc_s                             wr_acc_in,
  input  wire logic [GPB_WIDTH-1:0]                 wr_data_in,
  input  wire gpb_acc_s                             rd_acc_in,
  output logic      [GPB_WIDTH-1:0]                 rd_data_out,
  input  wire logic [GPB_NPORT-1:0][GPB_WIDTH-1:0]  pin_in,
  output logic      [GPB_NPORT-1:0][GPB_WIDTH-1:0]  pin_out,
  output logic      [GPB_NPORT-1:0][GPB_WIDTH-1:0]  pin_oe_n_out,
  output logic      [GPB_NPORT-1:0][GPB_WIDTH-1:0]  pullup_en_out,
  output logic      [GPB_NPORT-1:0][GPB_WIDTH-1:0]  pin_level_out,
  output logic      [GPB_WIDTH-1:0]                 ext_irq_n_out,
  input  wire logic [GPB_NPORT-1:0][GPB_WIDTH-1:0]  periph_oe_in,
  input  wire logic [GPB_NPORT-1:0][GPB_WIDTH-1:0]  periph_data_in
);

  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] dir_r;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] latch_r;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] ibuf_r;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] pull_r;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] odrain_r;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] sync1_r;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] sync2_r;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] pin_nxt;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] oe_n_nxt;
  logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] pull_nxt;
  logic [2:0]                          wr_idx;
  logic [2:0]                          rd_idx;

  assign wr_idx = wr_acc_in.port;
  assign rd_idx = rd_acc_in.port;

  // Writes to a register the port lacks are dropped
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_r <= {GPB_NPORT{GPB_DIR_RST}};
    end else if (wr_en_in && wr_acc_in.sel == REG_DIR
                 && GPB_HAS_DIR[wr_idx]) begin
      dir_r[wr_idx] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_r <= {GPB_NPORT{GPB_LATCH_RST}};
    end else if (wr_en_in && wr_acc_in.sel == REG_LATCH
                 && GPB_HAS_DIR[wr_idx]) begin
      latch_r[wr_idx] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ibuf_r <= {GPB_NPORT{GPB_IBUF_RST}};
    end else if (wr_en_in && wr_acc_in.sel == REG_IBUF) begin
      ibuf_r[wr_idx] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pull_r <= {GPB_NPORT{GPB_PULL_RST}};
    end else if (wr_en_in && wr_acc_in.sel == REG_PULL
                 && GPB_HAS_PULL[wr_idx]) begin
      pull_r[wr_idx] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      odrain_r <= {GPB_NPORT{GPB_ODRAIN_RST}};
    end else if (wr_en_in && wr_acc_in.sel == REG_ODRAIN
                 && GPB_HAS_ODRAIN[wr_idx]) begin
      odrain_r[wr_idx] <= wr_data_in;
    end
  end

  // Pins are asynchronous to the clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // Buffer off reads zero, so a floating pin costs no input current
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_level_out <= '0;
    end else begin
      pin_level_out <= sync2_r & ibuf_r;
    end
  end

  // Interrupt inputs idle high while the buffer is off
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_irq_n_out <= '1;
    end else begin
      ext_irq_n_out <= sync2_r[PORT_1] | ~ibuf_r[PORT_1];
    end
  end

  always_comb begin
    logic per_oe;
    logic val;
    logic drv;
    logic [GPB_WIDTH-1:0] mask;
    per_oe = 1'b0;
    val = 1'b0;
    drv = 1'b0;
    mask = '0;
    pin_nxt = '0;
    oe_n_nxt = '1;
    pull_nxt = '0;
    for (int p = 0; p < GPB_NPORT; p++) begin
      mask = (p == 0) ? GPB_P1_OUT_MASK : GPB_P2_OUT_MASK;
      for (int b = 0; b < GPB_WIDTH; b++) begin
        per_oe = GPB_HAS_PERIPH[p] & mask[b] & periph_oe_in[p][b];
        val = per_oe ? periph_data_in[p][b] : latch_r[p][b];
        drv = per_oe | (GPB_HAS_DIR[p] & dir_r[p][b]);
        // High side off in open-drain mode: a one leaves the pin released
        if (drv && !(odrain_r[p][b] && val)) begin
          oe_n_nxt[p][b] = 1'b0;
          pin_nxt[p][b] = val;
        end
        pull_nxt[p][b] = pull_r[p][b] & ~drv;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_out <= '0;
      pin_oe_n_out <= '1;
      pullup_en_out <= '0;
    end else begin
      pin_out <= pin_nxt;
      pin_oe_n_out <= oe_n_nxt;
      pullup_en_out <= pull_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      case (rd_acc_in.sel)
        REG_DIR:    rd_data_out <= dir_r[rd_idx];
        REG_LATCH:  rd_data_out <= latch_r[rd_idx];
        REG_LEVEL:  rd_data_out <= pin_level_out[rd_idx];
        REG_IBUF:   rd_data_out <= ibuf_r[rd_idx];
        REG_PULL:   rd_data_out <= pull_r[rd_idx];
        REG_ODRAIN: rd_data_out <= odrain_r[rd_idx];
        default:    rd_data_out <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  dir_write_a: assert property (
    wr_en_in && wr_acc_in == {PORT_1, REG_DIR}
    |=> dir_r[PORT_1] == $past(wr_data_in))
    else $error("direction write not stored");

  latch_write_a: assert property (
    wr_en_in && wr_acc_in == {PORT_2, REG_LATCH}
    |=> latch_r[PORT_2] == $past(wr_data_in))
    else $error("latch write not stored");

  level_read_a: assert property (
    rd_acc_in == {PORT_D, REG_LEVEL}
    |=> rd_data_out == $past(pin_level_out[PORT_D]))
    else $error("level read mismatch");

  ibuf_off_a: assert property (
    ibuf_r[PORT_E] == 8'h00 |=> pin_level_out[PORT_E] == 8'h00)
    else $error("disabled buffer reads nonzero");

  p5_input_only_a: assert property (
    pin_oe_n_out[PORT_5] == 8'hFF && dir_r[PORT_5] == 8'h00
    && latch_r[PORT_5] == 8'h00)
    else $error("port 5 has output state");

  pull_absent_a: assert property (
    pullup_en_out[PORT_1] == 8'h00 && pullup_en_out[PORT_2] == 8'h00
    && pullup_en_out[PORT_5] == 8'h00)
    else $error("pull-up on port without one");

  odrain_high_a: assert property (
    odrain_r[PORT_F][0] && dir_r[PORT_F][0] && latch_r[PORT_F][0]
    |=> pin_oe_n_out[PORT_F][0])
    else $error("open-drain pin drives high");

  p1_input_bit_a: assert property (
    !dir_r[PORT_1][3] |=> pin_oe_n_out[PORT_1][3])
    else $error("input-only peripheral bit driven");

  periph_wins_a: assert property (
    periph_oe_in[PORT_2][7] && !odrain_r[PORT_2][7]
    |=> !pin_oe_n_out[PORT_2][7]
        && pin_out[PORT_2][7] == $past(periph_data_in[PORT_2][7]))
    else $error("peripheral output not on pin");

  gpio_drive_a: assert property (
    !dir_r[PORT_D][1] |=> pin_oe_n_out[PORT_D][1])
    else $error("input pin driven");

  gpio_value_a: assert property (
    dir_r[PORT_H][2] && !odrain_r[PORT_H][2]
    |=> !pin_oe_n_out[PORT_H][2]
        && pin_out[PORT_H][2] == $past(latch_r[PORT_H][2]))
    else $error("output pin not driving latch");

endmodule

// ---- sim/gpb_board_model.sv ----
// Purpose: Board circuitry on the port pins of the general I/O port bank.
// Assumes: One resolved level per pin; a weak pull-down on every board net.
// Notes:   A released pin with no pull-up and no board drive reads low through
//          the board pull-down, so a stale driven value can never pass for input.
`timescale 1ns/10ps
module gpb_board_model
  import gpb_pkg::*;
(
  input  wire logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] pin_out_in,
  input  wire logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] pin_oe_n_in,
  input  wire logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] pullup_en_in,
  input  wire logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] ext_en_in,
  input  wire logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] ext_val_in,
  output logic      [GPB_NPORT-1:0][GPB_WIDTH-1:0] pin_level_out
);
  // Device drive wins, then board drive, then the on-chip pull-up
  assign pin_level_out = (~pin_oe_n_in & pin_out_in)
                       | (pin_oe_n_in & ext_en_in & ext_val_in)
                       | (pin_oe_n_in & ~ext_en_in & pullup_en_in);
endmodule

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the general I/O port bank.
// Assumes: Control writes one cycle each; pins settle within five edges.
// Notes:   Expected values come from the port capabilities, the values written and the board drive.
`timescale 1ns/10ps
module tb;
  import gpb_pkg::*;
  typedef logic [GPB_NPORT-1:0][GPB_WIDTH-1:0] gpb_bank_t;
  logic       clk_in, rst_n_in, wr_en_in;
  gpb_acc_s   wr_acc_in, rd_acc_in;
  logic [7:0] wr_data_in, rd_data_out, ext_irq_n_out, got;
  gpb_bank_t  pin_in, pin_out, pin_oe_n_out, pullup_en_out, pin_level_out;
  gpb_bank_t  periph_oe_in, periph_data_in, ext_en, ext_val;
  int         bad_count, n_checks;
  gpb_port_bank dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wr_en_in(wr_en_in), .wr_acc_in(wr_acc_in), .wr_data_in(wr_data_in),
    .rd_acc_in(rd_acc_in), .rd_data_out(rd_data_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out),
    .pullup_en_out(pullup_en_out), .pin_level_out(pin_level_out),
    .ext_irq_n_out(ext_irq_n_out), .periph_oe_in(periph_oe_in),
    .periph_data_in(periph_data_in));
  gpb_board_model board_u (.pin_out_in(pin_out), .pin_oe_n_in(pin_oe_n_out),
    .pullup_en_in(pullup_en_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pin_level_out(pin_in));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic wr(input gpb_port_e p, input gpb_reg_e s,
                    input logic [7:0] d);
    @(posedge clk_in);
    wr_en_in   <= 1'b1;
    wr_acc_in  <= '{port: p, sel: s};
    wr_data_in <= d;
    @(posedge clk_in);
    wr_en_in   <= 1'b0;
  endtask
  task automatic rd(input gpb_port_e p, input gpb_reg_e s);
    @(posedge clk_in);
    rd_acc_in <= '{port: p, sel: s};
    @(posedge clk_in);
    #1 got = rd_data_out;
  endtask
  // Register, one edge to pins, two through the synchroniser, one into the level register
  task automatic settle();
    repeat (5) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    final_report();
  end
  initial begin
    rst_n_in = 1'b0;
    wr_en_in = 1'b0;
    wr_acc_in = '0;
    rd_acc_in = '0;
    wr_data_in = '0;
    periph_oe_in = '0;
    periph_data_in = '0;
    ext_en = '1;
    ext_val = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(PORT_1, REG_DIR);
    chk(got, 8'h00);
    chk(pin_oe_n_out[0], 8'hFF);
    $display("test reset done");
    wr(PORT_2, REG_DIR, 8'hA5);
    wr(PORT_2, REG_LATCH, 8'h3C);
    rd(PORT_2, REG_DIR);
    chk(got, 8'hA5);
    rd(PORT_2, REG_LATCH);
    chk(got, 8'h3C);
    settle();
    chk(pin_oe_n_out[1], 8'h5A);
    chk(pin_out[1], 8'h24);
    // Bit 7 is already an output, so only the override can set it
    @(posedge clk_in);
    periph_oe_in[1] <= 8'h8F;
    periph_data_in[1] <= 8'h85;
    settle();
    chk(pin_oe_n_out[1], 8'h50);
    chk(pin_out[1], 8'hA5);
    @(posedge clk_in);
    periph_oe_in[1] <= 8'h00;
    wr(PORT_H, REG_DIR, 8'h04);
    wr(PORT_H, REG_LATCH, 8'h04);
    settle();
    chk(pin_oe_n_out[6], 8'hFB);
    chk(pin_out[6], 8'h04);
    $display("test direction and latch done");
    wr(PORT_2, REG_ODRAIN, 8'hFF);
    wr(PORT_2, REG_DIR, 8'hFF);
    settle();
    chk(pin_oe_n_out[1], 8'h3C);
    wr(PORT_F, REG_ODRAIN, 8'h01);
    wr(PORT_F, REG_DIR, 8'h03);
    wr(PORT_F, REG_LATCH, 8'h03);
    settle();
    chk(pin_oe_n_out[5], 8'hFD);
    chk(pin_out[5], 8'h02);
    wr(PORT_D, REG_ODRAIN, 8'hFF);
    rd(PORT_D, REG_ODRAIN);
    chk(got, 8'h00);
    $display("test open drain done");
    wr(PORT_5, REG_DIR, 8'hFF);
    wr(PORT_5, REG_LATCH, 8'hFF);
    rd(PORT_5, REG_DIR);
    chk(got, 8'h00);
    rd(PORT_5, REG_LATCH);
    chk(got, 8'h00);
    settle();
    chk(pin_oe_n_out[2], 8'hFF);
    $display("test input only port done");
    ext_val[3] <= 8'h5A;
    wr(PORT_D, REG_IBUF, 8'hFF);
    settle();
    rd(PORT_D, REG_LEVEL);
    chk(got, 8'h5A);
    wr(PORT_D, REG_IBUF, 8'h0F);
    settle();
    chk(pin_level_out[3], 8'h0A);
    rd(PORT_D, REG_IBUF);
    chk(got, 8'h0F);
    $display("test level and buffer done");
    ext_en[3] <= 8'h00;
    wr(PORT_D, REG_PULL, 8'hF0);
    wr(PORT_D, REG_IBUF, 8'hFF);
    settle();
    chk(pullup_en_out[3], 8'hF0);
    chk(pin_level_out[3], 8'hF0);
    // Driven pins drop their pull-up and show the latch level instead
    wr(PORT_D, REG_DIR, 8'h30);
    settle();
    chk(pullup_en_out[3], 8'hC0);
    chk(pin_level_out[3], 8'hC0);
    wr(PORT_1, REG_PULL, 8'hFF);
    rd(PORT_1, REG_PULL);
    chk(got, 8'h00);
    $display("test pull-up done");
    ext_val[0] <= 8'h0F;
    wr(PORT_1, REG_IBUF, 8'hFF);
    settle();
    chk(ext_irq_n_out, 8'h0F);
    wr(PORT_1, REG_IBUF, 8'h00);
    settle();
    chk(ext_irq_n_out, 8'hFF);
    @(posedge clk_in);
    periph_oe_in[0] <= 8'hFF;
    periph_data_in[0] <= 8'hAA;
    settle();
    chk(pin_oe_n_out[0], 8'h88);
    chk(pin_out[0], 8'h22);
    $display("test shared port pins done");
    final_report();
  end
endmodule
